// ### rtl/glue_pkg.sv
/*
  package for the local bus glue: cycle-type codes, vector codes, arbiter owners.
  assumes one local bus clock shared by processor and bridge.
*/
package glue_pkg;
  localparam int CYCLE_TYPE_W = 4;
  localparam int VECTOR_W = 4;
  localparam logic [3:0] CYCLE_LOCKED = 4'hB;
  localparam logic [3:0] VEC_NONE = 4'hF;
  localparam logic [3:0] VEC_SERIAL = 4'hD;
  localparam logic [3:0] VEC_BRIDGE = 4'hE;
  localparam logic [3:0] VEC_EXP0 = 4'hB;
  localparam logic [3:0] VEC_EXP1 = 4'h7;
  localparam int BUS_CLOCK_MHZ = 33;
  localparam int CORE_MULT_NOJUMPER = 3;
  localparam int CORE_MULT_JUMPER = 2;
  typedef enum logic [1:0] {OWN_BRIDGE, OWN_CPU, OWN_EXP} owner_t;
endpackage

// ### rtl/glue_if.sv
/*
  interface joining the glue logic and the processor/bridge/expansion side.
  assumes both ends share clk_i.
*/
`timescale 1ns/1ps
interface glue_if;
  logic cpu_cycle_begin_n;
  logic [3:0] cpu_cycle_type;
  logic cpu_ready_in;
  logic cpu_hold_req_n;
  logic cpu_hold_ack_n;
  logic cpu_irq_request;
  logic [3:0] irq_vector_n;
  logic cpu_nonmaskable_req_n;
  logic local_addr_strobe_n;
  logic final_beat_n;
  logic bridge_lock_in;
  logic bridge_ready_out_n;
  logic bridge_hold_req;
  logic bridge_hold_ack;
  logic bridge_local_irq_out_n;
  logic bridge_local_irq_in_n;
  logic local_system_error_n;
  logic deadlock_backoff_req;
  logic expansion_bus_req_n;
  logic expansion_bus_grant_n;
  logic expansion_irq0_n;
  logic expansion_irq1_n;
  logic serial_port_irq_n;
  logic core_multiplier_sel;
  modport glue (
    input cpu_cycle_begin_n, cpu_cycle_type, cpu_hold_ack_n, bridge_ready_out_n, bridge_hold_req,
    input bridge_local_irq_out_n, local_system_error_n, deadlock_backoff_req, expansion_bus_req_n,
    input expansion_irq0_n, expansion_irq1_n, serial_port_irq_n,
    output cpu_ready_in, cpu_hold_req_n, cpu_irq_request, irq_vector_n, cpu_nonmaskable_req_n,
    output local_addr_strobe_n, final_beat_n, bridge_lock_in, bridge_hold_ack, bridge_local_irq_in_n,
    output expansion_bus_grant_n, core_multiplier_sel
  );
  modport board (
    output cpu_cycle_begin_n, cpu_cycle_type, cpu_hold_ack_n, bridge_ready_out_n, bridge_hold_req,
    output bridge_local_irq_out_n, local_system_error_n, deadlock_backoff_req, expansion_bus_req_n,
    output expansion_irq0_n, expansion_irq1_n, serial_port_irq_n,
    input cpu_ready_in, cpu_hold_req_n, cpu_irq_request, irq_vector_n, cpu_nonmaskable_req_n,
    input local_addr_strobe_n, final_beat_n, bridge_lock_in, bridge_hold_ack, bridge_local_irq_in_n,
    input expansion_bus_grant_n, core_multiplier_sel
  );
endinterface

// ### rtl/bus_glue.sv
/*
  glue end of the local bus between the processor, the bridge and the expansion master.
  holds the three-master arbiter and the lock tracking across locked sequences,
  the translation of cycle start, ready, lock and last beat,
  the interrupt merge with its active-low vector,
  and the routing of system error and back-off to the processor nmi.
  arbitration: back-off takes the bus from the processor at once and keeps it with the bridge
  until it is withdrawn; otherwise the bridge comes before the expansion master,
  and while the lock state is set neither takes the bus from the processor, nor the expansion master from the bridge.
  assumes clk_i is the shared 33 MHz local bus clock and every pin input is
  synchronous to it; the processor end answers its hold request by mirroring it;
  every interrupt source is level triggered and holds until it is serviced;
  en_i low freezes the arbiter and the lock state.
*/
`timescale 1ns/1ps
module bus_glue (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  // board pins
  glue_if.glue bus,
  // user side
  input wire logic jumper_fitted_i,
  output logic [1:0] owner_o,
  output logic locked_o
);
  ////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    glue_pkg::owner_t owner;
    logic locked;
  } state_t;

  localparam state_t RESET_ST = '{owner: glue_pkg::OWN_CPU, locked: 1'b0};

  state_t st;
  state_t next_st;

  ////////////////////////////////////////////////////////////////
  // helpers
  // one source: its own code while active, all ones while idle
  function automatic logic [glue_pkg::VECTOR_W-1:0] vec_of(
    input logic act,
    input logic [glue_pkg::VECTOR_W-1:0] code
  );
    vec_of = act ? code : glue_pkg::VEC_NONE;
  endfunction

  // whether the given master holds the bus now
  function automatic logic owned_by(
    input glue_pkg::owner_t cur,
    input glue_pkg::owner_t who
  );
    owned_by = (cur == who);
  endfunction

  // next owner once the present one lets go
  function automatic glue_pkg::owner_t after_release(
    input logic bridge_next,
    input logic exp_next
  );
    if (bridge_next) begin
      after_release = glue_pkg::OWN_BRIDGE;
    end else if (exp_next) begin
      after_release = glue_pkg::OWN_EXP;
    end else begin
      after_release = glue_pkg::OWN_CPU;
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // pin decode
  logic serial_act;
  logic bridge_act;
  logic exp0_act;
  logic exp1_act;
  logic cycle_start;
  logic lock_cycle;
  logic bridge_wants;
  logic exp_wants;
  logic backoff;
  logic grant_ok;

  assign serial_act = !bus.serial_port_irq_n;
  assign bridge_act = !bus.bridge_local_irq_out_n;
  assign exp0_act = !bus.expansion_irq0_n;
  assign exp1_act = !bus.expansion_irq1_n;
  assign cycle_start = !bus.cpu_cycle_begin_n;
  assign lock_cycle = cycle_start && (bus.cpu_cycle_type == glue_pkg::CYCLE_LOCKED);
  assign bridge_wants = bus.bridge_hold_req;
  assign exp_wants = !bus.expansion_bus_req_n;
  assign backoff = bus.deadlock_backoff_req;
  assign grant_ok = !bus.cpu_hold_ack_n;

  ////////////////////////////////////////////////////////////////
  // lock tracking and arbiter
  always_comb begin
    next_st = st;
    if (lock_cycle) begin
      next_st.locked = 1'b1;
    end else if (cycle_start) begin
      next_st.locked = 1'b0;
    end
    case (st.owner)
      glue_pkg::OWN_CPU: begin
        if (backoff) begin
          next_st.owner = glue_pkg::OWN_BRIDGE;
        end else if (!st.locked && bridge_wants) begin
          next_st.owner = glue_pkg::OWN_BRIDGE;
        end else if (!st.locked && exp_wants) begin
          next_st.owner = glue_pkg::OWN_EXP;
        end
      end
      glue_pkg::OWN_BRIDGE: begin
        if (!bridge_wants && !backoff) begin
          next_st.owner = after_release(1'b0, exp_wants && !st.locked);
        end
      end
      glue_pkg::OWN_EXP: begin
        if (!exp_wants) begin
          next_st.owner = after_release(bridge_wants, 1'b0);
        end
      end
      default: begin
        next_st.owner = glue_pkg::OWN_CPU;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= RESET_ST;
    end else if (en_i) begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////
  // cycle translation
  assign bus.local_addr_strobe_n = bus.cpu_cycle_begin_n;
  assign bus.cpu_ready_in = !bus.bridge_ready_out_n;
  assign bus.bridge_lock_in = lock_cycle || (st.locked && !cycle_start);
  assign bus.final_beat_n = bus.cpu_cycle_begin_n;
  assign bus.core_multiplier_sel = jumper_fitted_i;

  ////////////////////////////////////////////////////////////////
  // hold and grants
  assign bus.cpu_hold_req_n = owned_by(st.owner, glue_pkg::OWN_CPU);
  assign bus.bridge_hold_ack = owned_by(st.owner, glue_pkg::OWN_BRIDGE) && grant_ok;
  assign bus.expansion_bus_grant_n = !(owned_by(st.owner, glue_pkg::OWN_EXP) && grant_ok);

  ////////////////////////////////////////////////////////////////
  // interrupts
  logic [glue_pkg::VECTOR_W-1:0] vector;
  logic any_other;

  always_comb begin
    vector = glue_pkg::VEC_NONE;
    vector = vector & vec_of(serial_act, glue_pkg::VEC_SERIAL);
    vector = vector & vec_of(bridge_act, glue_pkg::VEC_BRIDGE);
    vector = vector & vec_of(exp0_act, glue_pkg::VEC_EXP0);
    vector = vector & vec_of(exp1_act, glue_pkg::VEC_EXP1);
  end

  assign any_other = serial_act | exp0_act | exp1_act;
  assign bus.irq_vector_n = vector;
  assign bus.cpu_irq_request = bridge_act | any_other;
  assign bus.bridge_local_irq_in_n = !any_other;

  ////////////////////////////////////////////////////////////////
  // errors and back-off
  logic nmi_from_error;
  logic nmi_from_backoff;

  assign nmi_from_error = !bus.local_system_error_n;
  assign nmi_from_backoff = backoff;
  assign bus.cpu_nonmaskable_req_n = !(nmi_from_error || nmi_from_backoff);

  ////////////////////////////////////////////////////////////////
  // user side
  assign owner_o = st.owner;
  assign locked_o = st.locked;
endmodule

// ### rtl/board_end.sv
/*
  far end: drives the processor, bridge and expansion pins from user requests,
  keeping the lock order, level interrupts and back-off release.
  assumes the glue end on the same interface and clock.
*/
`timescale 1ns/1ps
module board_end (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  // board pins
  glue_if.board bus,
  // user side
  input wire logic start_i,
  input wire logic lock_i,
  input wire logic [3:0] irq_n_i,
  input wire logic serr_n_i,
  input wire logic backoff_i,
  input wire logic bridge_ready_n_i,
  input wire logic bridge_hold_i,
  input wire logic exp_req_n_i,
  output logic cpu_owns_o
);
  typedef struct packed {
    logic began;
    logic lock_read_done;
  } state_t;
  state_t st, next_st;
  logic may_start;
  assign may_start = start_i && !backoff_i && bus.cpu_hold_req_n;

  always_comb begin
    next_st = st;
    next_st.began = may_start;
    if (may_start && lock_i) begin
      next_st.lock_read_done = 1'b1;
    end else if (may_start) begin
      next_st.lock_read_done = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= '0;
    end else if (en_i) begin
      st <= next_st;
    end
  end

  assign bus.cpu_cycle_begin_n = !st.began;
  assign bus.cpu_cycle_type = st.lock_read_done ? glue_pkg::CYCLE_LOCKED : 4'h0;
  assign bus.cpu_hold_ack_n = bus.cpu_hold_req_n;
  assign bus.bridge_ready_out_n = bridge_ready_n_i;
  assign bus.bridge_hold_req = bridge_hold_i;
  assign bus.bridge_local_irq_out_n = irq_n_i[0];
  assign bus.serial_port_irq_n = irq_n_i[1];
  assign bus.expansion_irq0_n = irq_n_i[2];
  assign bus.expansion_irq1_n = irq_n_i[3];
  assign bus.local_system_error_n = serr_n_i;
  assign bus.deadlock_backoff_req = backoff_i;
  assign bus.expansion_bus_req_n = exp_req_n_i;
  assign cpu_owns_o = bus.cpu_hold_req_n;
endmodule

// ### testbench/glue_assertions.sv
/*
  checker for the glue pins: lock, strobe, interrupt merge, nmi, expansion grant.
  assumes it sits beside the interface, one clock, reset active low.
*/
`timescale 1ns/1ps
module glue_checker (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // cycle and lock
  input wire logic cpu_cycle_begin_n,
  input wire logic [3:0] cpu_cycle_type,
  input wire logic local_addr_strobe_n,
  input wire logic bridge_lock_in,
  // interrupts and nmi
  input wire logic cpu_irq_request,
  input wire logic [3:0] irq_vector_n,
  input wire logic bridge_local_irq_in_n,
  input wire logic bridge_local_irq_out_n,
  input wire logic serial_port_irq_n,
  input wire logic expansion_irq0_n,
  input wire logic expansion_irq1_n,
  input wire logic cpu_nonmaskable_req_n,
  input wire logic local_system_error_n,
  input wire logic deadlock_backoff_req,
  // expansion master
  input wire logic expansion_bus_req_n,
  input wire logic expansion_bus_grant_n
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  wire lk = !cpu_cycle_begin_n && cpu_cycle_type == glue_pkg::CYCLE_LOCKED;
  wire others_idle = serial_port_irq_n && expansion_irq0_n && expansion_irq1_n;
  wire [3:0] vec_expect = {expansion_irq1_n, expansion_irq0_n, serial_port_irq_n, bridge_local_irq_out_n};
  ////////////////////////////////////////////////////////////////////////////
  lock_on_strobe_a: assert property (lk |-> !local_addr_strobe_n && bridge_lock_in)
    else $error("lock not raised with locked strobe");
  strobe_follow_a: assert property (local_addr_strobe_n == cpu_cycle_begin_n)
    else $error("strobe does not follow cycle begin");
  lock_kept_a: assert property (lk ##1 cpu_cycle_begin_n [*2] |-> bridge_lock_in)
    else $error("lock dropped without new cycle");
  irq_merge_a: assert property (cpu_irq_request == !(bridge_local_irq_out_n && others_idle))
    else $error("irq request wrong");
  bridge_irq_excl_a: assert property (bridge_local_irq_in_n == others_idle)
    else $error("bridge irq input wrong");
  vector_and_a: assert property (irq_vector_n == vec_expect)
    else $error("vector wrong");
  nmi_merge_a: assert property (cpu_nonmaskable_req_n == (local_system_error_n && !deadlock_backoff_req))
    else $error("nmi wrong");
  grant_cause_a: assert property ($fell(expansion_bus_grant_n) |-> !$past(expansion_bus_req_n))
    else $error("grant without request");
  cover_lock_c: cover property (lk);
  cover_grant_c: cover property ($fell(expansion_bus_grant_n));
  cover_nmi_c: cover property (deadlock_backoff_req && !cpu_nonmaskable_req_n);
endmodule

// ### testbench/tb_local_bus_glue_irq_lock_arbiter.sv
/*
  testbench: glue end and board end joined by the interface, user sides driven.
  assumes inputs change at the falling edge.
*/
`timescale 1ns/1ps
module tb_local_bus_glue_irq_lock_arbiter;
  logic clk_i, nrst_i, jmp, start, lock, serr_n, boff, rdy_n, hold, xreq_n, locked, owns;
  logic [3:0] irq_n = 4'hF;
  logic en = 1'b1;
  logic [1:0] owner;
  int failures = 0;
  int num_checks = 0;
  int n;
  glue_if bus();
  bus_glue i_bus_glue (.clk_i, .nrst_i, .en_i(en), .bus(bus), .jumper_fitted_i(jmp), .owner_o(owner),
    .locked_o(locked));
  board_end i_board_end (.clk_i, .nrst_i, .en_i(en), .bus(bus), .start_i(start), .lock_i(lock),
    .irq_n_i(irq_n), .serr_n_i(serr_n), .backoff_i(boff), .bridge_ready_n_i(rdy_n), .bridge_hold_i(hold),
    .exp_req_n_i(xreq_n), .cpu_owns_o(owns));
  glue_checker i_glue_checker (.clk_i, .nrst_i, .cpu_cycle_begin_n(bus.cpu_cycle_begin_n),
    .cpu_cycle_type(bus.cpu_cycle_type), .local_addr_strobe_n(bus.local_addr_strobe_n),
    .bridge_lock_in(bus.bridge_lock_in), .cpu_irq_request(bus.cpu_irq_request),
    .irq_vector_n(bus.irq_vector_n), .bridge_local_irq_in_n(bus.bridge_local_irq_in_n),
    .bridge_local_irq_out_n(bus.bridge_local_irq_out_n), .serial_port_irq_n(bus.serial_port_irq_n),
    .expansion_irq0_n(bus.expansion_irq0_n), .expansion_irq1_n(bus.expansion_irq1_n),
    .cpu_nonmaskable_req_n(bus.cpu_nonmaskable_req_n), .local_system_error_n(bus.local_system_error_n),
    .deadlock_backoff_req(bus.deadlock_backoff_req), .expansion_bus_req_n(bus.expansion_bus_req_n),
    .expansion_bus_grant_n(bus.expansion_bus_grant_n));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 0;
    forever #2.5 clk_i = ~clk_i;
  end
  task chk(input logic [3:0] s, input logic [3:0] e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("ERROR %0t: got %h want %h", $time, s, e);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(negedge clk_i);
  endtask
  task test_done;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task t_irq;
    for (int i = 0; i < 16; i++) begin
      irq_n = i[3:0];
      cyc(2);
      chk(bus.irq_vector_n, irq_n);
      chk(bus.cpu_irq_request, !(&irq_n));
      chk(bus.bridge_local_irq_in_n, &irq_n[3:1]);
    end
    irq_n = 4'hF;
  endtask
  task t_nmi;
    for (int i = 0; i < 4; i++) begin
      {boff, serr_n} = i[1:0];
      {jmp, rdy_n} = i[1:0];
      cyc(2);
      chk(bus.cpu_nonmaskable_req_n, serr_n & !boff);
      chk(bus.cpu_ready_in, !rdy_n);
      chk(bus.core_multiplier_sel, jmp);
      chk(owns, !boff);
    end
    {boff, serr_n, rdy_n} = 3'h3;
  endtask
  task t_cycle(input logic l);
    start = 1;
    lock = l;
    for (n = 0; n < 8 && bus.cpu_cycle_begin_n !== 1'b0; n++) cyc(1);
    chk(bus.local_addr_strobe_n, 0);
    chk(bus.final_beat_n, 0);
    chk(bus.bridge_lock_in, l);
    start = 0;
    cyc(3);
  endtask
  task t_lock;
    t_cycle(1);
    chk(locked, 1);
    xreq_n = 0;
    cyc(4);
    chk(bus.expansion_bus_grant_n, 1);
    t_cycle(0);
    for (n = 0; n < 8 && bus.expansion_bus_grant_n !== 1'b0; n++) cyc(1);
    chk(bus.expansion_bus_grant_n, 0);
    chk(owner, 4'(glue_pkg::OWN_EXP));
    xreq_n = 1;
    cyc(3);
  endtask
  task t_hold;
    en = 0;
    hold = 1;
    cyc(3);
    chk(owner, 4'(glue_pkg::OWN_CPU));
    en = 1;
    for (n = 0; n < 8 && bus.bridge_hold_ack !== 1'b1; n++) cyc(1);
    chk(bus.bridge_hold_ack, 1);
    chk(owns, 0);
    chk(owner, 4'(glue_pkg::OWN_BRIDGE));
    hold = 0;
    cyc(3);
  endtask
  initial begin
    {nrst_i, jmp, start, lock, boff, hold} = 0;
    {serr_n, rdy_n, xreq_n} = 3'h7;
    repeat (12) @(negedge clk_i);
    nrst_i = 1;
    t_irq();
    t_nmi();
    t_lock();
    t_hold();
    test_done();
  end
  initial begin
    #100000;
    failures++;
    test_done();
  end
endmodule
